// ### rtl/lin_slave_protocol_handler.v
`timescale 1ns/1ps
`include "lin_slave_map.vh"

// Overview of operation
// RULE_01: full read reports, clears three motion flags
// RULE_02: short read clears only lost-step flag
// RULE_03: 8-bit error register, bits 3..0 used
// RULE_04: checksum, stop or length fault sets data
// RULE_05: parity or sync fault sets header error
// RULE_06: overlong frame sets timeout error
// RULE_07: driven bit differs from bus, bit error
// RULE_08: full read frame clears error register
// RULE_09: address from four OTP, three strap bits
// RULE_10: select bit picks address bit arrangement
// RULE_11: identifier, 2/4/8 data bytes, checksum
// RULE_12: inverted carry-wrapped sum over data only
// RULE_13: bit rate 9.6 or 19.2 kbit/s
// RULE_14: bit timing learned from master sync
// RULE_15: accept writing frames for device control
// RULE_16: answer reads with position, status, config
// RULE_17: identifier bits 7 and 6 are parity
// RULE_18: identifier bits 5:4 give data length
// RULE_19: error bits sticky until full read
// RULE_20: act only on frames carrying own address; code also acts on frames with byte 1 bit 7 clear
module lin_slave_protocol_handler #(
  parameter [5:0]  FULL_READ_ID  = 6'h10,
  parameter [5:0]  SHORT_READ_ID = 6'h11,
  parameter [19:0] BRK_MIN       = `BRK_MIN_CYC,
  parameter [16:0] SYNC_MIN      = `SYNC_MIN_CYC,
  parameter [16:0] SYNC_MAX      = `SYNC_MAX_CYC
) (
  input  wire        clk,
  input  wire        rst,
  input  wire        ce,
  input  wire        linIn,
  output wire        linOut,
  output wire        linOeN,
  input  wire [2:0]  strapAddrPins,
  input  wire [3:0]  otpAddrBits,
  input  wire        addrCombineSelect,
  input  wire [15:0] presentPosition,
  input  wire [7:0]  configReadback,
  input  wire [4:0]  statusBits,
  input  wire        lostStepSet,
  input  wire        blockedRotorSet,
  input  wire        absoluteBlockSet,
  output wire        lostStepFlag,
  output wire        blockedRotorFlag,
  output wire        absoluteBlockFlag,
  output wire [7:0]  commErrorState,
  output wire        wrValid,
  output wire [7:0]  wrData,
  output wire        wrLast,
  input  wire        wrReady
);

  localparam [4:0] S_IDLE = 5'b00001;
  localparam [4:0] S_BRK  = 5'b00010;
  localparam [4:0] S_SYNC = 5'b00100;
  localparam [4:0] S_RX   = 5'b01000;
  localparam [4:0] S_TX   = 5'b10000;

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // carry wraps back into bit 0
  function [7:0] addc;
    input [7:0] a;
    input [7:0] b;
    reg   [8:0] s;
    begin
      s    = {1'b0, a} + {1'b0, b};
      addc = s[7:0] + {7'h00, s[8]};
    end
  endfunction

  function parOk;
    input [7:0] v;
    begin
      parOk = (v[6] == (v[0] ^ v[1] ^ v[2] ^ v[4])) &&
              (v[7] == ~(v[1] ^ v[3] ^ v[4] ^ v[5]));
    end
  endfunction

  function [3:0] lenOf;
    input [1:0] c;
    begin
      lenOf = (c == 2'b11) ? 4'd8 : (c == 2'b10) ? 4'd4 : 4'd2;
    end
  endfunction

  // allowed frame length in bit times
  function [7:0] frameMax;
    input [3:0] n;
    reg   [15:0] t;
    begin
      t        = (`FRAME_HDR_BITS + 16'd10 * ({12'h000, n} + 16'd1)) * `FRAME_NUM;
      t        = t / `FRAME_DEN;
      frameMax = t[7:0];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // state

  reg [4:0]  st_r;
  reg        rxM_r, rxS_r, rxD_r;
  reg [2:0]  strapM_r, strapS_r;
  reg [6:0]  nodeAddr_r;
  reg [19:0] lowCnt_r;
  reg [16:0] syncCnt_r;
  reg [2:0]  edges_r;
  reg [13:0] bitT_r;
  reg [13:0] cnt_r;
  reg [3:0]  bit_r;
  reg        busy_r;
  reg [7:0]  sh_r;
  reg [3:0]  idx_r;
  reg [3:0]  len_r;
  reg [7:0]  sum_r;
  reg [21:0] frameCyc_r;
  reg [7:0]  buf_r [0:7];
  reg        drn_r;
  reg [2:0]  dIdx_r;
  reg [3:0]  errSet_r;
  reg        fullClr_r, shortClr_r;
  reg [7:0]  errState_r;
  reg        lostStep_r, blocked_r, absBlock_r;
  reg        oeN_r;

  wire        fall     = rxD_r & ~rxS_r;
  wire        inFrame  = (st_r == S_RX) || (st_r == S_TX);
  wire [19:0] brkLim   = inFrame ? ({6'h00, bitT_r} * 20'd11) : BRK_MIN;
  wire [21:0] toutLim  = {8'h00, bitT_r} * {14'h0000, frameMax(len_r)};
  wire [13:0] halfT    = {1'b0, bitT_r[13:1]};
  wire        txBit    = (bit_r == 4'd0) ? 1'b0 :
                         (bit_r <= 4'd8) ? sh_r[bit_r[2:0] - 3'd1] : 1'b1;
  wire [3:0]  idxN     = (bit_r == 4'hF) ? idx_r : idx_r + 4'd1;
  wire        idxData  = (idxN <= len_r);
  wire [7:0]  dataN    = buf_r[idxN[2:0] - 3'd1];
  wire [7:0]  nxtByte  = idxData ? dataN : ~sum_r;
  wire        bufReady;

  assign linOut            = 1'b0;
  assign linOeN            = oeN_r;
  assign commErrorState    = errState_r;
  assign lostStepFlag      = lostStep_r;
  assign blockedRotorFlag  = blocked_r;
  assign absoluteBlockFlag = absBlock_r;

  ////////////////////////////////////////////////////////////////////////
  // accepted write data toward the motion logic
  // RULE_15: write frame out
  lin_skid_buffer #(
    .W(9)
  ) wrBuf (
    .clk      (clk),
    .rst      (rst),
    .ce       (ce),
    .inValid  (drn_r),
    .inData   ({(dIdx_r == len_r[2:0] - 3'd1), buf_r[dIdx_r]}),
    .inReady  (bufReady),
    .outValid (wrValid),
    .outData  ({wrLast, wrData}),
    .outReady (wrReady)
  );

  ////////////////////////////////////////////////////////////////////////
  // sticky status, pin sync and node address
  always @(posedge clk) begin
    if (rst) begin
      rxM_r      <= 1'b1;
      rxS_r      <= 1'b1;
      rxD_r      <= 1'b1;
      strapM_r   <= 3'h0;
      strapS_r   <= 3'h0;
      nodeAddr_r <= 7'h00;
      errState_r <= `ERR_RST;
      lostStep_r <= 1'b0;
      blocked_r  <= 1'b0;
      absBlock_r <= 1'b0;
      lowCnt_r   <= 20'h00000;
      oeN_r      <= 1'b1;
    end else if (ce) begin
      rxM_r    <= linIn;
      rxS_r    <= rxM_r;
      rxD_r    <= rxS_r;
      strapM_r <= strapAddrPins;
      strapS_r <= strapM_r;
      // RULE_09: address build
      // RULE_10: combine select
      nodeAddr_r <= addrCombineSelect ? {strapS_r[2], otpAddrBits, strapS_r[1:0]}
                                      : {otpAddrBits, strapS_r};
      // RULE_19: sticky, set wins
      // RULE_08: full read clears
      // RULE_03: upper bits stay zero
      errState_r <= (fullClr_r ? `ERR_RST : errState_r) | {4'h0, errSet_r};
      // RULE_01: full read clears
      // RULE_02: short read clears
      lostStep_r <= ((fullClr_r | shortClr_r) ? 1'b0 : lostStep_r) | lostStepSet;
      blocked_r  <= (fullClr_r ? 1'b0 : blocked_r) | blockedRotorSet;
      absBlock_r <= (fullClr_r ? 1'b0 : absBlock_r) | absoluteBlockSet;
      // saturating low-run counter for break detection
      // limit can shrink mid-run when the state changes, hence the compare
      lowCnt_r <= rxS_r ? 20'h00000 : (lowCnt_r >= brkLim ? lowCnt_r : lowCnt_r + 20'd1);
      // open-drain: enable low only while a dominant bit is sent
      oeN_r <= !((st_r == S_TX) && !txBit);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // frame sequencer
  always @(posedge clk) begin
    if (rst) begin
      st_r       <= S_IDLE;
      syncCnt_r  <= 17'h00000;
      edges_r    <= 3'h0;
      bitT_r     <= 14'h0000;
      cnt_r      <= 14'h0000;
      bit_r      <= 4'h0;
      busy_r     <= 1'b0;
      sh_r       <= 8'h00;
      idx_r      <= 4'h0;
      len_r      <= 4'd8;
      sum_r      <= 8'h00;
      frameCyc_r <= 22'h000000;
      drn_r      <= 1'b0;
      dIdx_r     <= 3'h0;
      errSet_r   <= 4'h0;
      fullClr_r  <= 1'b0;
      shortClr_r <= 1'b0;
    end else if (ce) begin
      errSet_r   <= 4'h0;
      fullClr_r  <= 1'b0;
      shortClr_r <= 1'b0;
      frameCyc_r <= frameCyc_r + 22'd1;
      // drain stalls on back-pressure, never drops a byte
      if (drn_r && bufReady) begin
        dIdx_r <= dIdx_r + 3'd1;
        if (dIdx_r == len_r[2:0] - 3'd1)
          drn_r <= 1'b0;
      end
      case (st_r)
        S_IDLE: ;
        S_BRK: begin
          if (rxS_r) begin
            st_r      <= S_SYNC;
            edges_r   <= 3'h0;
            syncCnt_r <= 17'h00000;
          end
        end
        // RULE_14: learn bit time
        S_SYNC: begin
          if (edges_r != 3'h0)
            syncCnt_r <= syncCnt_r + 17'd1;
          if (fall) begin
            edges_r <= edges_r + 3'd1;
            if (edges_r == 3'd4) begin
              // RULE_13: rate window
              // RULE_05: sync fault
              if (syncCnt_r < SYNC_MIN) begin
                errSet_r[`ERR_HDR_POS] <= 1'b1;
                st_r <= S_IDLE;
              end else begin
                bitT_r     <= syncCnt_r[16:3];
                st_r       <= S_RX;
                busy_r     <= 1'b0;
                idx_r      <= 4'h0;
                len_r      <= 4'd8;
                frameCyc_r <= 22'h000000;
              end
            end
          end else if (syncCnt_r > SYNC_MAX) begin
            errSet_r[`ERR_HDR_POS] <= 1'b1;
            st_r <= S_IDLE;
          end
        end
        S_RX: begin
          if (!busy_r) begin
            if (fall) begin
              busy_r <= 1'b1;
              cnt_r  <= halfT;
              bit_r  <= 4'h0;
            end
          end else if (cnt_r != 14'h0000) begin
            cnt_r <= cnt_r - 14'h0001;
          end else begin
            cnt_r <= bitT_r;
            bit_r <= bit_r + 4'd1;
            if (bit_r == 4'h0 && rxS_r) begin
              busy_r <= 1'b0; // start glitch, wait again
            end else if (bit_r >= 4'd1 && bit_r <= 4'd8) begin
              sh_r <= {rxS_r, sh_r[7:1]};
            end else if (bit_r == 4'd9) begin
              busy_r <= 1'b0;
              idx_r  <= idx_r + 4'd1;
              // RULE_04: stop bit fault
              if (!rxS_r) begin
                errSet_r[`ERR_DATA_POS] <= 1'b1;
                st_r <= S_IDLE;
              end else if (idx_r == 4'h0) begin
                // RULE_17: identifier parity
                // RULE_05: parity fault
                if (!parOk(sh_r)) begin
                  errSet_r[`ERR_HDR_POS] <= 1'b1;
                  st_r <= S_IDLE;
                end else begin
                  // RULE_18: length code
                  len_r <= lenOf(sh_r[5:4]);
                  sum_r <= 8'h00;
                  // RULE_16: read snapshot
                  if ((sh_r[5:0] == FULL_READ_ID || sh_r[5:0] == SHORT_READ_ID) &&
                      !drn_r) begin
                    buf_r[`RSP_ADDR]   <= {1'b1, nodeAddr_r};
                    buf_r[`RSP_ERR]    <= errState_r | {4'h0, errSet_r};
                    buf_r[`RSP_FLAGS]  <= {lostStep_r | lostStepSet,
                                           blocked_r | blockedRotorSet,
                                           absBlock_r | absoluteBlockSet, statusBits};
                    buf_r[`RSP_POS_HI] <= presentPosition[15:8];
                    buf_r[`RSP_POS_LO] <= presentPosition[7:0];
                    buf_r[`RSP_CFG]    <= configReadback;
                    buf_r[6]           <= `RSP_PAD;
                    buf_r[7]           <= `RSP_PAD;
                    fullClr_r  <= (sh_r[5:0] == FULL_READ_ID);
                    shortClr_r <= (sh_r[5:0] == SHORT_READ_ID);
                    st_r  <= S_TX;
                    bit_r <= 4'hF; // one idle bit before the answer
                  end
                end
              end else if (idx_r <= len_r) begin
                // RULE_11: data bytes
                buf_r[idx_r[2:0] - 3'd1] <= sh_r;
                sum_r <= addc(sum_r, sh_r);
              end else begin
                // RULE_12: checksum compare
                st_r <= S_IDLE;
                if (sh_r != ~sum_r)
                  errSet_r[`ERR_DATA_POS] <= 1'b1;
                // RULE_20: own address, or byte 1 bit 7 clear
                else if (!buf_r[1][7] || buf_r[1][6:0] == nodeAddr_r) begin
                  drn_r  <= 1'b1;
                  dIdx_r <= 3'h0;
                end
              end
            end
          end
        end
        S_TX: begin
          if (cnt_r != 14'h0000) begin
            cnt_r <= cnt_r - 14'h0001;
            // RULE_07: readback compare
            if (cnt_r == halfT && bit_r != 4'hF && rxS_r != txBit) begin
              errSet_r[`ERR_BIT_POS] <= 1'b1;
              st_r <= S_IDLE;
            end
          end else begin
            cnt_r <= bitT_r;
            if (bit_r == 4'd9 && idx_r == len_r + 4'd1) begin
              st_r <= S_IDLE;
            end else if (bit_r == 4'd9 || bit_r == 4'hF) begin
              // RULE_12: checksum sent last
              idx_r <= idxN;
              bit_r <= 4'h0;
              sh_r  <= nxtByte;
              if (idxData)
                sum_r <= addc(sum_r, dataN);
            end else begin
              bit_r <= bit_r + 4'd1;
            end
          end
        end
        default: st_r <= S_IDLE;
      endcase
      // RULE_06: frame too long
      if (inFrame && frameCyc_r > toutLim) begin
        errSet_r[`ERR_TOUT_POS] <= 1'b1;
        st_r <= S_IDLE;
      end
      // RULE_04: break cuts frame short
      if (rxS_r == 1'b0 && lowCnt_r >= brkLim && st_r != S_BRK) begin
        if (inFrame)
          errSet_r[`ERR_DATA_POS] <= 1'b1;
        st_r <= S_BRK;
      end
    end
  end

endmodule

// ### shared/lin_slave_map.vh
`ifndef LIN_SLAVE_MAP_VH
`define LIN_SLAVE_MAP_VH

////////////////////////////////////////////////////////////////////////
// timing, all derived from the 100 MHz core clock
`define CLK_PERIOD_NS   10
`define BIT_NS_FAST     52083
`define BIT_NS_SLOW     104167
`define BRK_BITS        11
// least break length: round up to whole cycles
`define BRK_MIN_CYC     ((`BRK_BITS*`BIT_NS_FAST+`CLK_PERIOD_NS-1)/`CLK_PERIOD_NS)
// sync span is eight bit times, with 15 percent slack each way
`define SYNC_MIN_CYC    ((8*`BIT_NS_FAST*85/100+`CLK_PERIOD_NS-1)/`CLK_PERIOD_NS)
`define SYNC_MAX_CYC    (8*`BIT_NS_SLOW*115/100/`CLK_PERIOD_NS)

////////////////////////////////////////////////////////////////////////
// frame length budget in bit times: (header + 10*(n+1)) * 1.4
`define FRAME_HDR_BITS  16'd34
`define FRAME_NUM       16'd14
`define FRAME_DEN       16'd10

////////////////////////////////////////////////////////////////////////
// comm_error_state layout
`define ERR_BIT_POS     0
`define ERR_HDR_POS     1
`define ERR_DATA_POS    2
`define ERR_TOUT_POS    3
`define ERR_RST         8'h00

////////////////////////////////////////////////////////////////////////
// response byte layout of reading frames
`define RSP_ADDR        3'd0
`define RSP_ERR         3'd1
`define RSP_FLAGS       3'd2
`define RSP_POS_HI      3'd3
`define RSP_POS_LO      3'd4
`define RSP_CFG         3'd5
`define RSP_PAD         8'hFF

`endif

// ### rtl/lin_skid_buffer.v
`timescale 1ns/1ps

// two-entry buffer: output register plus one spare slot
module lin_skid_buffer #(
  parameter W = 9
) (
  input  wire         clk,
  input  wire         rst,
  input  wire         ce,
  input  wire         inValid,
  input  wire [W-1:0] inData,
  output wire         inReady,
  output reg          outValid,
  output reg  [W-1:0] outData,
  input  wire         outReady
);

  reg [W-1:0] spare_r;
  reg         spareV_r;

  // ready only needs the spare slot, so it is a plain flop output
  assign inReady = !spareV_r;

  ////////////////////////////////////////////////////////////////////////
  // head moves when drained or empty; else incoming word parks in spare
  always @(posedge clk) begin
    if (rst) begin
      outValid <= 1'b0;
      outData  <= {W{1'b0}};
      spare_r  <= {W{1'b0}};
      spareV_r <= 1'b0;
    end else if (ce) begin
      if (outReady || !outValid) begin
        if (spareV_r) begin
          outData  <= spare_r;
          outValid <= 1'b1;
          spareV_r <= 1'b0;
        end else begin
          outData  <= inData;
          outValid <= inValid;
        end
      end else if (inValid && !spareV_r) begin
        spare_r  <= inData;
        spareV_r <= 1'b1;
      end
    end
  end

endmodule

// ### verif/lin_master_model.sv
`timescale 1ns/1ps

// bus master: drives frames, reads in-frame answers
module lin_master_model #(
  parameter int BIT = 20
) (
  input  wire logic clk,
  input  wire logic linOeN,
  output wire logic linIn
);
  logic lvl = 1'b1;

  // fixed bit time
  // wired-and bus with pull-up: either side may pull dominant
  assign linIn = lvl & linOeN;

  task automatic bits(input logic v, input int n);
    lvl = v;
    repeat (n * BIT) @(posedge clk);
    #1;
  endtask

  task automatic send_byte(input logic [7:0] b);
    bits(1'b0, 1);
    for (int i = 0; i < 8; i++) bits(b[i], 1);
    bits(1'b1, 1);
  endtask

  function automatic logic [7:0] pid(input logic [5:0] id);
    return {~(id[1] ^ id[3] ^ id[4] ^ id[5]), id[0] ^ id[1] ^ id[2] ^ id[4], id};
  endfunction

  function automatic logic [7:0] cks(input logic [7:0] dd[8], input int n);
    logic [8:0] s;
    s = 9'h000;
    for (int i = 0; i < n; i++) begin
      s = {1'b0, s[7:0]} + {1'b0, dd[i]};
      s = {1'b0, s[7:0]} + {8'h00, s[8]};
    end
    return ~s[7:0];
  endfunction

  // break of 13 bits, delimiter, sync byte, identifier
  task automatic header(input logic [7:0] idb);
    bits(1'b0, 13);
    bits(1'b1, 1);
    send_byte(8'h55);
    send_byte(idb);
  endtask

  task automatic frame(input logic [7:0] idb, input logic [7:0] dd[8], input int n,
                       input logic [7:0] cx);
    header(idb);
    for (int i = 0; i < n; i++) send_byte(dd[i]);
    send_byte(cks(dd, n) ^ cx);
  endtask

  // waits a bounded time for a start bit, samples mid-bit
  task automatic recv_byte(output logic [7:0] b, output logic ok);
    int t;
    t = 0;
    while (linIn && t < 40 * BIT) begin
      @(posedge clk);
      t++;
    end
    ok = !linIn;
    repeat (BIT + BIT / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      b[i] = linIn;
      repeat (BIT) @(posedge clk);
    end
    #1;
  endtask
endmodule

// ### verif/lin_slave_props.sv
`timescale 1ns/1ps

// port-level checks of the slave handler
module lin_slave_props (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       ce,
  input wire logic       linOut,
  input wire logic       linOeN,
  input wire logic       lostStepSet,
  input wire logic       blockedRotorSet,
  input wire logic       absoluteBlockSet,
  input wire logic       lostStepFlag,
  input wire logic       blockedRotorFlag,
  input wire logic       absoluteBlockFlag,
  input wire logic [7:0] commErrorState,
  input wire logic       wrValid,
  input wire logic [7:0] wrData,
  input wire logic       wrLast,
  input wire logic       wrReady
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // stall then hold steps of the write handshake
  sequence stallSeq;
    wrValid && !wrReady;
  endsequence
  sequence heldSeq;
    wrValid && $stable(wrData) && $stable(wrLast);
  endsequence
  // some error bit dropped since last cycle
  sequence errDropSeq;
    ($past(commErrorState) & commErrorState) != $past(commErrorState);
  endsequence

  chk_upper_zero: assert property (commErrorState[7:4] == 4'h0)
    else $error("unused error bits set");
  chk_lost_set: assert property (ce && lostStepSet |=> lostStepFlag)
    else $error("lost-step flag not set");
  chk_block_set: assert property (ce && blockedRotorSet |=> blockedRotorFlag)
    else $error("blocked flag not set");
  chk_err_together: assert property (errDropSeq |-> (($past(commErrorState) & commErrorState) == 8'h00))
    else $error("error bits cleared one by one");
  chk_full_clear: assert property ($fell(blockedRotorFlag) |-> !lostStepFlag && commErrorState == 8'h00)
    else $error("blocked flag cleared without full clear");
  chk_abs_pair: assert property ($fell(absoluteBlockFlag) |-> !blockedRotorFlag && !lostStepFlag)
    else $error("absolute block flag cleared alone");
  chk_wr_hold: assert property (stallSeq |=> heldSeq)
    else $error("write byte changed while stalled");
  chk_last_valid: assert property (wrLast |-> wrValid)
    else $error("last marker without valid");
  chk_out_tied: assert property (linOut == 1'b0)
    else $error("bus data pin not dominant level");
endmodule

// ### verif/tb.sv
`timescale 1ns/1ps

module tb;
  logic       clk = 1'b0;
  logic       ce = 1'b1;
  logic       rst = 1'b1;
  logic       addrCombineSelect = 1'b0;
  logic       lostStepSet = 1'b0;
  logic       blockedRotorSet = 1'b0;
  logic       absoluteBlockSet = 1'b0;
  logic       wrReady = 1'b1;
  logic       stall = 1'b0;
  logic [2:0] strapAddrPins = 3'h7;
  logic [3:0] otpAddrBits = 4'hA;
  logic [15:0] presentPosition = 16'h0000;
  logic [7:0] configReadback = 8'h00;
  logic [4:0] statusBits = 5'h00;
  wire        linIn, linOut, linOeN, wrValid, wrLast;
  wire        lostStepFlag, blockedRotorFlag, absoluteBlockFlag;
  wire  [7:0] commErrorState, wrData;
  int         errors = 0;
  int         checks = 0;
  int         cyc = 0;
  logic [8:0] got[$];
  logic [7:0] d[8];
  logic [7:0] rx;
  logic       ok;

  // full read gets an eight-byte code so every answer byte is seen
  lin_slave_protocol_handler #(.FULL_READ_ID(6'h30), .BRK_MIN(20'd200), .SYNC_MIN(17'd80),
                               .SYNC_MAX(17'd400)) i_dut (
    .clk(clk), .rst(rst), .ce(ce), .linIn(linIn), .linOut(linOut), .linOeN(linOeN),
    .strapAddrPins(strapAddrPins), .otpAddrBits(otpAddrBits),
    .addrCombineSelect(addrCombineSelect), .presentPosition(presentPosition),
    .configReadback(configReadback), .statusBits(statusBits), .lostStepSet(lostStepSet),
    .blockedRotorSet(blockedRotorSet), .absoluteBlockSet(absoluteBlockSet),
    .lostStepFlag(lostStepFlag), .blockedRotorFlag(blockedRotorFlag),
    .absoluteBlockFlag(absoluteBlockFlag), .commErrorState(commErrorState),
    .wrValid(wrValid), .wrData(wrData), .wrLast(wrLast), .wrReady(wrReady));

  lin_master_model i_master (.clk(clk), .linOeN(linOeN), .linIn(linIn));

  ////////////////////////////////////////////////////////////////////////
  // clock
  initial begin
    forever #5 clk = ~clk;
  end

  // sink collects {last, data}; optional stall pattern
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (wrValid && wrReady) got.push_back({wrLast, wrData});
    wrReady <= #1 (stall ? cyc[2] : 1'b1);
  end

  task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // one-cycle pulse on all three motion flag sets
  task automatic pulse_sets();
    lostStepSet = 1'b1;
    blockedRotorSet = 1'b1;
    absoluteBlockSet = 1'b1;
    @(posedge clk);
    #1;
    lostStepSet = 1'b0;
    blockedRotorSet = 1'b0;
    absoluteBlockSet = 1'b0;
  endtask

  function automatic logic [6:0] nodeAddr();
    return addrCombineSelect ? {strapAddrPins[2], otpAddrBits, strapAddrPins[1:0]}
                             : {otpAddrBits, strapAddrPins};
  endfunction

  // send a frame, then compare what reached the sink
  task automatic wframe(input logic [5:0] id, input int n, input logic [7:0] cx, input int expn);
    got.delete();
    i_master.frame(i_master.pid(id), d, n, cx);
    repeat (80) @(posedge clk);
    #1;
    check("count", 9'(got.size()), 9'(expn)); // forwarded count
    for (int i = 0; i < expn && i < got.size(); i++)
      check("byte", got[i], {i == n - 1, d[i]}); // bytes and last marker
  endtask

  ////////////////////////////////////////////////////////////////////////
  // hang guard, well above the expected run
  initial begin
    repeat (60000) @(posedge clk);
    errors++;
    give_verdict();
  end

  initial begin
    repeat (5) @(posedge clk);
    #1 rst = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    check("idle", {wrValid, linOeN, lostStepFlag, blockedRotorFlag, absoluteBlockFlag,
                   commErrorState[3:0]}, 9'h080); // reset state
    // every length code, both address arrangements, with and without stall
    for (int k = 0; k < 4; k++) begin
      addrCombineSelect = k[0];
      stall = k[1];
      // strap bit 0 stays high so the short read's first data bit is recessive
      strapAddrPins = 3'(7 - 2 * k);
      otpAddrBits = 4'(10 + k);
      for (int i = 0; i < 8; i++) d[i] = 8'h81 + 8'(i * 17);
      d[1] = {1'b1, nodeAddr()};
      wframe(6'h05 + 6'(k * 16), (k < 2) ? 2 : 2 << (k - 1), 8'h00,
             (k < 2) ? 2 : 2 << (k - 1));
    end
    d[1] = {1'b1, nodeAddr() ^ 7'h01};
    wframe(6'h05, 2, 8'h00, 0); // foreign address
    check("err", {1'b0, commErrorState}, 9'h000); // no fault
    d[1] = 8'h12;
    wframe(6'h25, 4, 8'h01, 0); // bad sum
    check("err", {1'b0, commErrorState}, 9'h004); // data fault
    i_master.frame(i_master.pid(6'h05) ^ 8'h80, d, 2, 8'h00);
    repeat (40) @(posedge clk);
    #1;
    check("err", {1'b0, commErrorState}, 9'h006); // parity fault
    i_master.header(i_master.pid(6'h05));
    i_master.send_byte(8'h81);
    repeat (2000) @(posedge clk);
    #1;
    check("err", {1'b0, commErrorState}, 9'h00E); // overlong frame
    // clock enable low: set pulses must not reach the flags
    ce = 1'b0;
    pulse_sets();
    check("frozen", {6'h00, lostStepFlag, blockedRotorFlag, absoluteBlockFlag}, 9'h000);
    ce = 1'b1;
    pulse_sets();
    check("flags", {6'h00, lostStepFlag, blockedRotorFlag, absoluteBlockFlag}, 9'h007);
    // short read, master holds the bus dominant for four bit times after the header
    i_master.header(i_master.pid(6'h11));
    i_master.bits(1'b0, 4);
    i_master.bits(1'b1, 1);
    repeat (400) @(posedge clk);
    #1;
    check("err", {1'b0, commErrorState}, 9'h00F); // readback fault
    check("flags", {6'h00, lostStepFlag, blockedRotorFlag, absoluteBlockFlag}, 9'h003);
    // full read: eight answer bytes, checksum, then everything clear
    presentPosition = 16'hA55A;
    configReadback = 8'h3C;
    statusBits = 5'h15;
    d[0] = {1'b1, nodeAddr()};
    d[1] = 8'h0F;
    d[2] = {3'b011, statusBits};
    d[3] = presentPosition[15:8];
    d[4] = presentPosition[7:0];
    d[5] = configReadback;
    d[6] = 8'hFF;
    d[7] = 8'hFF;
    i_master.header(i_master.pid(6'h30));
    i_master.recv_byte(rx, ok);
    check("addr", {ok, rx}, {1'b1, d[0]}); // address byte
    i_master.recv_byte(rx, ok);
    check("errByte", {ok, rx}, {1'b1, d[1]}); // error byte
    for (int i = 2; i < 8; i++) begin
      i_master.recv_byte(rx, ok);
      check("answer", {ok, rx}, {1'b1, d[i]}); // flags, position, config, padding
    end
    i_master.recv_byte(rx, ok);
    check("sum", {ok, rx}, {1'b1, i_master.cks(d, 8)}); // answer sum
    repeat (20) @(posedge clk);
    #1;
    check("err", {1'b0, commErrorState}, 9'h000); // cleared
    check("flags", {6'h00, lostStepFlag, blockedRotorFlag, absoluteBlockFlag}, 9'h000);
    give_verdict();
  end
endmodule

bind lin_slave_protocol_handler lin_slave_props i_props (
  .clk(clk), .rst(rst), .ce(ce), .linOut(linOut), .linOeN(linOeN), .lostStepSet(lostStepSet),
  .blockedRotorSet(blockedRotorSet), .absoluteBlockSet(absoluteBlockSet),
  .lostStepFlag(lostStepFlag), .blockedRotorFlag(blockedRotorFlag),
  .absoluteBlockFlag(absoluteBlockFlag), .commErrorState(commErrorState),
  .wrValid(wrValid), .wrData(wrData), .wrLast(wrLast), .wrReady(wrReady));
